/* File: acrp_consts.svh */
`ifndef ACRP_CONSTS_SVH
`define ACRP_CONSTS_SVH
// ----------------------------------------
// field widths
// ----------------------------------------
`define ACRP_SWING_W      3
`define ACRP_EMPH_W       5
`define ACRP_DCG_W        2
`define ACRP_EQ_W         4
// ----------------------------------------
// direction-select codes
// ----------------------------------------
`define ACRP_DIR_NOP      2'h0
`define ACRP_DIR_RX       2'h1
`define ACRP_DIR_TX       2'h2
`define ACRP_DIR_BOTH     2'h3
// ----------------------------------------
// timing and reset values
// ----------------------------------------
`define ACRP_CAL_CYCLES   16
`define ACRP_XFER_CYCLES  4
`define ACRP_CNT_W        8
`define ACRP_CNT_ZERO     8'h00
`define ACRP_CNT_ONE      8'h01
`endif

/* File: acrp_ctrl.sv */
// Behaviour
// [R1] channel select used only with several channels; a one-channel read still indexes chan[op_ch] by it
// [R2] addressed fields fixed width 3/5/2/4
// [R3] code 2'b10 touches transmit side only
// [R4] requester sets values, channel, direction first
// [R5] requester checks busy low before write
// [R6] write strobe is one cycle pulse
// [R7] busy high during write, low after
// [R8] read: set channel/direction, then one-cycle strobe
// [R9] busy high during read, low after
// [R10] read-valid flags readback data valid
// [R11] read and write never together
// [R12] addressed write updates selected channel only
// [R13] addressed read returns selected channel settings
// [R14] shared write reconfigures every channel
// [R15] shared write copies one value everywhere
// [R16] shared readback concatenates per-channel fields
// [R17] channel zero packed at least significant end
// [R18] power-up: busy low, then high during calibration
// [R19] 01 receive, 11 both, 00 nothing
// [R20] strobes during busy are ignored
// [R21] valid pulses once; readback holds value
`include "acrp_consts.svh"
`default_nettype none
module acrp_ctrl #(
	parameter int NCH    = 4,
	parameter bit SHARED = 1'b0,
	parameter int CAL    = `ACRP_CAL_CYCLES,
	parameter int XFER   = `ACRP_XFER_CYCLES,
	parameter int CHW    = (NCH > 1) ? $clog2(NCH) : 1
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         write_strobe,
	input  wire logic                         read_strobe,
	input  wire logic [CHW-1:0]               channel_sel,
	input  wire logic [1:0]                   dir_sel,
	input  wire acrp_pkg::acrp_set_type       wr_set,
	output var  logic                         busy,
	output var  logic                         read_valid,
	output var  logic [NCH*`ACRP_SWING_W-1:0] rd_swing,
	output var  logic [NCH*`ACRP_EMPH_W-1:0]  rd_emph,
	output var  logic [NCH*`ACRP_DCG_W-1:0]   rd_dcg,
	output var  logic [NCH*`ACRP_EQ_W-1:0]    rd_eq
);
	import acrp_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// channel hit: shared mode hits all, single-channel hits its only one
	function automatic logic hit(input int ch, input logic [CHW-1:0] sel);
		hit = SHARED || (NCH == 1) || (sel == CHW'(ch)); // [R1] [R12] [R14]
	endfunction
	function automatic logic tx_on(input logic [1:0] d);
		tx_on = (d == `ACRP_DIR_TX) || (d == `ACRP_DIR_BOTH); // [R3] [R19]
	endfunction
	function automatic logic rx_on(input logic [1:0] d);
		rx_on = (d == `ACRP_DIR_RX) || (d == `ACRP_DIR_BOTH); // [R19]
	endfunction

	acrp_state_type            state;
	logic [`ACRP_CNT_W-1:0]    cnt;
	acrp_set_type              chan [NCH];
	logic [CHW-1:0]            op_ch;
	logic [1:0]                op_dir;
	acrp_set_type              op_set;
	logic                      done;

	assign done = (cnt == `ACRP_CNT_ONE);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// strobes are only sampled in idle, so nothing is queued while busy
	always_ff @(posedge clk)
	begin
		if (rst)
			state <= ACRP_IDLE0;
		else
			unique case (state)
				ACRP_IDLE0: state <= ACRP_CAL; // [R18]
				ACRP_CAL:   if (done) state <= ACRP_IDLE;
				ACRP_IDLE:
					if (write_strobe && !read_strobe) state <= ACRP_WRITE; // [R11] [R20]
					else if (read_strobe && !write_strobe) state <= ACRP_READ; // [R11]
				ACRP_WRITE: if (done) state <= ACRP_IDLE; // [R7]
				ACRP_READ:  if (done) state <= ACRP_IDLE; // [R9]
				default:    state <= ACRP_IDLE;
			endcase
	end

	// cycle counter for calibration and transfers
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt <= `ACRP_CNT_ZERO;
		else if (state == ACRP_IDLE0)
			cnt <= `ACRP_CNT_W'(CAL);
		else if (state == ACRP_IDLE && (write_strobe ^ read_strobe))
			cnt <= `ACRP_CNT_W'(XFER);
		else if (cnt != `ACRP_CNT_ZERO)
			cnt <= cnt - `ACRP_CNT_ONE;
	end

	// latch request so mid-transaction input changes do no harm
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			op_ch  <= '0;
			op_dir <= `ACRP_DIR_NOP;
			op_set <= '0;
		end
		else if (state == ACRP_IDLE && (write_strobe ^ read_strobe))
		begin
			op_ch  <= channel_sel; // [R4] [R8]
			op_dir <= dir_sel;
			op_set <= wr_set;
		end
	end

	// busy: low in the first cycle after reset, high while working
	always_ff @(posedge clk)
	begin
		if (rst)
			busy <= 1'b0;
		else
			busy <= (state == ACRP_IDLE0) || ((state != ACRP_IDLE) && !done) ||
				(state == ACRP_IDLE && (write_strobe ^ read_strobe)); // [R7] [R9] [R18] [R20]
	end

	// ----------------------------------------
	// channel settings store
	// ----------------------------------------
	// the last write cycle commits, so busy falls with the data in place
	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		always_ff @(posedge clk)
		begin
			if (rst)
				chan[g] <= '0;
			else if (state == ACRP_WRITE && done && hit(g, op_ch)) // [R12] [R14] [R15]
			begin
				if (tx_on(op_dir))
				begin
					chan[g].swing <= op_set.swing; // [R3]
					chan[g].emph  <= op_set.emph;
				end
				if (rx_on(op_dir))
				begin
					chan[g].dcg <= op_set.dcg;
					chan[g].eq  <= op_set.eq;
				end
			end
		end

		// shared mode packs channel g at slice g from the low end
		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				rd_swing[g*`ACRP_SWING_W +: `ACRP_SWING_W] <= '0;
				rd_emph[g*`ACRP_EMPH_W +: `ACRP_EMPH_W]    <= '0;
				rd_dcg[g*`ACRP_DCG_W +: `ACRP_DCG_W]       <= '0;
				rd_eq[g*`ACRP_EQ_W +: `ACRP_EQ_W]          <= '0;
			end
			else if (state == ACRP_READ && done && (SHARED || g == 0)) // [R16] [R17]
			begin
				if (tx_on(op_dir))
				begin
					rd_swing[g*`ACRP_SWING_W +: `ACRP_SWING_W] <= SHARED ? chan[g].swing : chan[op_ch].swing; // [R13]
					rd_emph[g*`ACRP_EMPH_W +: `ACRP_EMPH_W]    <= SHARED ? chan[g].emph : chan[op_ch].emph;
				end
				if (rx_on(op_dir))
				begin
					rd_dcg[g*`ACRP_DCG_W +: `ACRP_DCG_W] <= SHARED ? chan[g].dcg : chan[op_ch].dcg;
					rd_eq[g*`ACRP_EQ_W +: `ACRP_EQ_W]    <= SHARED ? chan[g].eq : chan[op_ch].eq; // [R2]
				end
			end
		end
	end

	// one-cycle valid, together with busy falling
	always_ff @(posedge clk)
	begin
		if (rst)
			read_valid <= 1'b0;
		else
			read_valid <= (state == ACRP_READ) && done; // [R10] [R21]
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// busy run length; a counter keeps the checks valid for any CAL and XFER from 1 to 255 without long repetitions
	logic [`ACRP_CNT_W-1:0]    busy_run;
	always_ff @(posedge clk)
	begin
		if (rst || !busy)
			busy_run <= `ACRP_CNT_ZERO;
		else
			busy_run <= busy_run + `ACRP_CNT_ONE;
	end

	power_busy_a: assert property ($fell(rst) |-> !busy ##1 busy) // [R18]
		else $error("busy not low then high after reset");
	cal_busy_a: assert property (state == ACRP_CAL && done |=> // [R18]
		!busy && busy_run == `ACRP_CNT_W'(CAL))
		else $error("calibration busy length wrong");
	busy_start_a: assert property (state == ACRP_IDLE && (write_strobe ^ read_strobe) |=> // [R7] [R9]
		busy && state != ACRP_IDLE)
		else $error("busy not raised after strobe");
	write_busy_a: assert property (state == ACRP_WRITE && done |=> // [R7]
		!busy && busy_run == `ACRP_CNT_W'(XFER))
		else $error("write busy length wrong");
	read_busy_a: assert property (state == ACRP_READ && done |=> // [R9] [R10]
		!busy && read_valid && busy_run == `ACRP_CNT_W'(XFER))
		else $error("read busy or valid wrong");
	valid_pulse_a: assert property (read_valid |=> !read_valid) // [R21]
		else $error("read valid longer than one cycle");
	valid_idle_a: assert property (read_valid |-> !busy) // [R21]
		else $error("valid while busy");
	ignore_busy_a: assert property (state != ACRP_IDLE && (write_strobe || read_strobe) |=> // [R20]
		$stable(op_set) && $stable(op_dir))
		else $error("strobe during busy taken");
	no_both_a: assert property (state == ACRP_IDLE && write_strobe && read_strobe |=> state == ACRP_IDLE) // [R11]
		else $error("simultaneous read and write started");
	hold_rd_a: assert property (state != ACRP_READ |=> $stable(rd_swing) && $stable(rd_eq)) // [R21]
		else $error("readback changed outside read");
	nop_dir_a: assert property (state == ACRP_WRITE && op_dir == `ACRP_DIR_NOP |=> // [R19]
		chan[op_ch] == $past(chan[op_ch]))
		else $error("nop direction changed settings");

	write_c: cover property (state == ACRP_IDLE && write_strobe ##5 !busy);
	read_c:  cover property (read_valid);
	cal_c:   cover property (state == ACRP_CAL ##1 state == ACRP_IDLE);
endmodule
`default_nettype wire

/* File: acrp_pkg.sv */
`default_nettype none
package acrp_pkg;
`include "acrp_consts.svh"
	// one channel's analog settings
	typedef struct packed {
		logic [`ACRP_SWING_W-1:0] swing;
		logic [`ACRP_EMPH_W-1:0]  emph;
		logic [`ACRP_DCG_W-1:0]   dcg;
		logic [`ACRP_EQ_W-1:0]    eq;
	} acrp_set_type;
	typedef enum logic [2:0] {ACRP_IDLE0, ACRP_CAL, ACRP_IDLE, ACRP_WRITE, ACRP_READ} acrp_state_type;
endpackage
`default_nettype wire

/* File: acrp_user.sv */
`default_nettype none
// ----------------------------------------
// requester model on the fabric side
// ----------------------------------------
module acrp_user (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic busy,
	input  wire logic go_wr,
	input  wire logic go_rd,
	output var  logic write_strobe,
	output var  logic read_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	// strobe for one cycle only while idle; own strobe blocks a repeat before busy rises
	always_ff @(posedge clk)
	begin
		write_strobe <= !rst && !busy && !write_strobe && !read_strobe && go_wr;
		read_strobe  <= !rst && !busy && !write_strobe && !read_strobe && go_rd;
	end
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import acrp_pkg::*;
	typedef struct packed {logic rd; logic [1:0] c; logic [1:0] d; acrp_set_type s;} acrp_row_type;
	logic         clk = 0, rst = 1, go_wr = 0, go_rd = 0, bad_ws = 0;
	logic         busy, read_valid, us_wr, us_rd;
	logic [1:0]   ch = 0, dir = 0;
	acrp_set_type wset = '0, rb = '0;
	acrp_set_type exp_set [4] = '{default: '0};
	logic [11:0]  rsw;
	logic [19:0]  rem;
	logic [7:0]   rdc;
	logic [15:0]  req;
	int           err_total = 0, n_compared = 0;
	// four writes, four reads, a rewrite of channel 1, then two reads; the last rows check that unselected readback halves hold
	acrp_row_type rows [11] = '{{1'b0, 2'h0, 2'h3, 14'h2a5b}, {1'b0, 2'h1, 2'h2, 14'h1234},
		{1'b0, 2'h2, 2'h1, 14'h3fff}, {1'b0, 2'h3, 2'h0, 14'h1555}, {1'b1, 2'h3, 2'h3, 14'h0},
		{1'b1, 2'h0, 2'h3, 14'h0}, {1'b1, 2'h1, 2'h3, 14'h0}, {1'b1, 2'h2, 2'h3, 14'h0},
		{1'b0, 2'h1, 2'h3, 14'h0f0f}, {1'b1, 2'h1, 2'h2, 14'h0}, {1'b1, 2'h1, 2'h1, 14'h0}};
	acrp_user acrp_user_inst (.clk(clk), .rst(rst), .busy(busy), .go_wr(go_wr), .go_rd(go_rd),
		.write_strobe(us_wr), .read_strobe(us_rd));
	acrp_ctrl #(.NCH(4), .SHARED(1'b0), .CAL(4), .XFER(1)) acrp_ctrl_inst (.clk(clk), .rst(rst),
		.write_strobe(us_wr | bad_ws), .read_strobe(us_rd | bad_ws), .channel_sel(ch), .dir_sel(dir), .wr_set(wset),
		.busy(busy), .read_valid(read_valid), .rd_swing(rsw), .rd_emph(rem), .rd_dcg(rdc), .rd_eq(req));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial
	forever #50 clk = ~clk;
	task automatic chk(input logic [63:0] seen, input logic [63:0] want);
		n_compared++;
		if (seen !== want)
		begin
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
			err_total++;
		end
	endtask
	task automatic give_verdict;
		$display("compared=%0d errors=%0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one transfer through the requester; expectations come from a local copy of the store
	task automatic xact(input logic rd, input logic [1:0] c, input logic [1:0] d, input acrp_set_type s);
		int i;
		// a one-cycle go is only seen while idle, so wait out calibration first
		for (i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk) #1;
		@(posedge clk);
		ch <= c;
		dir <= d;
		wset <= s;
		go_wr <= !rd;
		go_rd <= rd;
		@(posedge clk);
		go_wr <= 1'b0;
		go_rd <= 1'b0;
		if (!rd && d[1]) {exp_set[c].swing, exp_set[c].emph} = {s.swing, s.emph};
		if (!rd && d[0]) {exp_set[c].dcg, exp_set[c].eq} = {s.dcg, s.eq};
		if (rd && d[1]) {rb.swing, rb.emph} = {exp_set[c].swing, exp_set[c].emph};
		if (rd && d[0]) {rb.dcg, rb.eq} = {exp_set[c].dcg, exp_set[c].eq};
		for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk) #1;
		chk(busy, 1'b1);
		for (i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk) #1;
		chk(busy, 1'b0);
		if (rd)
		begin
			chk(read_valid, 1'b1);
			chk({rsw[2:0], rem[4:0], rdc[1:0], req[3:0]}, rb);
			chk({rsw[11:3], rem[19:5], rdc[7:2], req[15:4]}, 64'h0);
			@(posedge clk) #1;
			chk(read_valid, 1'b0);
		end
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(busy, 1'b0);
		@(posedge clk) #1;
		chk(busy, 1'b1);
		// strobes during calibration are dropped, so channel zero must still read zero
		@(posedge clk);
		bad_ws <= 1'b1;
		dir <= 2'h3;
		wset <= 14'h3fff;
		@(posedge clk);
		bad_ws <= 1'b0;
		xact(1'b1, 2'h0, 2'h3, 14'h0);
		// both strobes together while idle start nothing
		@(posedge clk);
		bad_ws <= 1'b1;
		@(posedge clk);
		bad_ws <= 1'b0;
		#1;
		chk(busy, 1'b0);
		foreach (rows[k]) xact(rows[k].rd, rows[k].c, rows[k].d, rows[k].s);
		give_verdict;
	end
	initial
	begin
		#300000;
		err_total++;
		give_verdict;
	end
endmodule
`default_nettype wire
